//--- design/timer_counter_pkg.sv
// Purpose: types shared by the timer/event counter files
// Assumes: nothing
// Notes: encodings live in timer_counter_regs.svh
package timer_counter_pkg;
	typedef enum logic [1:0] {RUN_IDLE, RUN_TIMER, RUN_EXT, RUN_EVENT} run_kind_type;
endpackage

//--- design/timer_counter_regs.svh
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH

// Purpose: encodings and timing counts of the timer/event counter
// Assumes: MCLK is the main oscillator clock, 20 MHz
// Notes: definitions only

// ----------------------------------------
// control field encodings
// ----------------------------------------
`define START_STOP 2'h0
`define START_CMD 2'h1
`define START_RISE 2'h2
`define START_FALL 2'h3
`define SRC_DIV11 2'h0
`define SRC_DIV7 2'h1
`define SRC_DIV3 2'h2
`define SRC_EXT 2'h3
`define MODE_TIMER 2'h0
`define MODE_WINDOW 2'h1
`define MODE_PULSE 2'h2
`define MODE_PPG 2'h3
`define METT_START_ONLY 1'h0
`define METT_START_STOP 1'h1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define COUNT_RESET 16'h0000
`define CAPTURE_RESET 16'h0000
`define PERIOD_RESET 16'hffff
`define PRESCALE_W 11
`define TAP_DIV11 11'h7ff
`define TAP_DIV7 11'h07f
`define TAP_DIV3 11'h007
`define LOW_TAP_DIV3 3'h7
// noise filter limits in main clock periods
`define FILT_REJECT_FC 4
`define FILT_DETECT_FC 12
`define FILT_STABLE_CYC ((`FILT_REJECT_FC + `FILT_DETECT_FC) / 2)

`endif

//--- design/timer_input_filter.sv
// Purpose: synchroniser and noise filter for the timer input pin
// Assumes: clk runs at the main oscillator rate
// Notes: filter is skipped in low speed and doze states
`include "timer_counter_regs.svh"

module timer_input_filter
	import timer_counter_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic pin,
	input wire logic bypass,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic [4:0] stable;
	wire agree = (s2 == s3);
	wire differs = agree && (s3 != level);
	wire settled = (stable == 5'(`FILT_STABLE_CYC - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			stable <= 5'h00;
			level <= 1'b0;
		end else if (ce) begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (!differs) begin
				stable <= 5'h00;
			end else if (bypass || settled) begin
				// low speed: two agreeing machine cycles are enough [R13]
				level <= s3;
				stable <= 5'h00;
			end else begin
				// short glitches never reach the settle count [R12]
				stable <= stable + 5'h01;
			end
		end
	end

	chk_filter_hold: assert property (@(posedge clk) disable iff (rst)
		ce && !bypass && !differs |=> level == $past(level)) // [R12]
		else $error("filtered level moved without a stable change");
endmodule

//--- design/timer_trigger_event_counter.sv
// Purpose: 16-bit timer, triggered timer and event counter
// Assumes: MCLK is the main oscillator clock; low clock arrives as a pin
// Notes: window, pulse width and pulse output selections hold the counter cleared
//
// Function
// (R01) six modes selectable; timer, trigger and event run, others hold cleared
// (R02) timer mode counts each prescaled source tick once started
// (R03) timer match raises irq, clears counter, counting goes on
// (R04) auto-capture copies counter into capture register every tick
// (R05) software waits one source tick before first capture read
// (R06) software reads capture only while running with capture enabled
// (R07) trigger mode waits for chosen pin edge, then counts ticks
// (R08) trigger mode match clears, halts and raises irq
// (R09) start-stop: opposite edge before match clears and halts, no irq
// (R10) halted trigger counter restarts from zero on next trigger edge
// (R11) start-only: opposite edge ignored, retrigger before match ignored
// (R12) normal speed filter rejects 4/fc pulses, detects 12/fc pulses
// (R13) low speed and doze bypass the input filter
// (R14) event mode counts each chosen pin edge
// (R15) event match checked on opposite edge: irq and clear
// (R16) pin levels last at least two machine cycles in event mode
// (R17) auto-capture also works in event mode
// (R18) source select: fc/2^11 or fs/2^3, fc/2^7, fc/2^3, pin
// (R19) mode select 00 timer family, 01 window, 10 pulse, 11 output
// (R20) trigger-stop bit: 0 start only, 1 start and stop
// (R21) stop entry forces start field to 00
// (R22) counter, period and capture are 16 bits; counter, capture reset zero
`include "timer_counter_regs.svh"

module timer_trigger_event_counter
	import timer_counter_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic CLK_EN,
	input wire logic TIMER_INPUT_PIN,
	input wire logic LOW_OSC_CLK,
	input wire logic START_WR,
	input wire logic [1:0] START_WDATA,
	input wire logic STOP_ENTRY,
	input wire logic PERIOD_WR,
	input wire logic [COUNT_W-1:0] PERIOD_WDATA,
	input wire logic [1:0] SOURCE_CLK_SEL,
	input wire logic [1:0] OP_MODE_SEL,
	input wire logic TRIGGER_STOP_SEL,
	input wire logic AUTO_CAPTURE_EN,
	input wire logic DIVIDER_TAP_SEL,
	input wire logic LOW_SPEED_STATE,
	input wire logic DOZE_STATE,
	output logic [1:0] START_CTRL_FIELD,
	output logic [COUNT_W-1:0] PERIOD_COMPARE_REG,
	output logic [COUNT_W-1:0] CAPTURE_REG,
	output logic [COUNT_W-1:0] COUNT_VALUE,
	output logic RUNNING,
	output logic MATCH_IRQ
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [`PRESCALE_W-1:0] prescale;
	logic low1;
	logic low2;
	logic low3;
	logic [2:0] low_div;
	logic pin_level;
	logic pin_prev;
	logic [COUNT_W-1:0] next_count;
	logic next_running;
	logic next_irq;
	logic advance;

	wire slow = LOW_SPEED_STATE || DOZE_STATE;
	wire low_rise = low2 && !low3;
	wire low_tick = low_rise && (low_div == `LOW_TAP_DIV3);
	wire div11_tick = (prescale == `TAP_DIV11);
	wire div7_tick = (prescale[6:0] == 7'(`TAP_DIV7));
	wire div3_tick = (prescale[2:0] == 3'(`TAP_DIV3));
	wire use_low = slow || DIVIDER_TAP_SEL;
	// internal source tick per select field [R18]
	wire src_tick = (SOURCE_CLK_SEL == `SRC_DIV11) ? (use_low ? low_tick : div11_tick) :
		(SOURCE_CLK_SEL == `SRC_DIV7) ? (!slow && div7_tick) :
		(SOURCE_CLK_SEL == `SRC_DIV3) ? (!slow && div3_tick) : 1'b0;
	wire rise = pin_level && !pin_prev;
	wire fall = !pin_level && pin_prev;
	wire falling_sel = (START_CTRL_FIELD == `START_FALL);
	wire trig_edge = falling_sel ? fall : rise;
	wire opp_edge = falling_sel ? rise : fall;
	wire at_period = (COUNT_VALUE == PERIOD_COMPARE_REG);
	wire edge_start = START_CTRL_FIELD[1];
	wire timer_family = (OP_MODE_SEL == `MODE_TIMER);
	// mode decode; other modes fall to idle and hold the counter cleared [R01] [R19]
	wire run_kind_type kind = !timer_family ? RUN_IDLE :
		(START_CTRL_FIELD == `START_CMD && SOURCE_CLK_SEL != `SRC_EXT) ? RUN_TIMER :
		(edge_start && SOURCE_CLK_SEL != `SRC_EXT) ? RUN_EXT :
		(edge_start && SOURCE_CLK_SEL == `SRC_EXT) ? RUN_EVENT : RUN_IDLE;

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	timer_input_filter u_filter (
		.clk(MCLK),
		.rst(SYS_RST),
		.ce(CLK_EN),
		.pin(TIMER_INPUT_PIN),
		.bypass(slow),
		.level(pin_level)
	);

	// ----------------------------------------
	// counter next state
	// ----------------------------------------
	always_comb begin
		next_count = COUNT_VALUE;
		next_running = RUNNING;
		next_irq = 1'b0;
		advance = 1'b0;
		case (kind)
			RUN_TIMER: begin
				next_running = 1'b1;
				if (src_tick) begin
					advance = 1'b1;
					if (at_period) begin
						// wrap and keep counting [R02] [R03]
						next_count = '0;
						next_irq = 1'b1;
					end else begin
						next_count = COUNT_VALUE + 1'b1;
					end
				end
			end
			RUN_EXT: begin
				if (!RUNNING) begin
					if (trig_edge) begin
						// start or restart from zero [R07] [R10]
						next_running = 1'b1;
						next_count = '0;
					end
				end else if (TRIGGER_STOP_SEL == `METT_START_STOP && opp_edge) begin
					// early release aborts silently [R09] [R20]
					next_running = 1'b0;
					next_count = '0;
				end else if (src_tick) begin
					// retrigger and start-only opposite edge fall through [R11]
					advance = 1'b1;
					if (at_period) begin
						next_running = 1'b0;
						next_count = '0;
						next_irq = 1'b1; // [R08]
					end else begin
						next_count = COUNT_VALUE + 1'b1;
					end
				end
			end
			RUN_EVENT: begin
				next_running = 1'b1;
				// pin levels shorter than two cycles may be missed [R16]
				if (trig_edge) begin
					advance = 1'b1;
					next_count = COUNT_VALUE + 1'b1; // [R14]
				end else if (opp_edge && at_period) begin
					next_count = '0;
					next_irq = 1'b1; // [R15]
				end
			end
			default: begin
				next_running = 1'b0;
				next_count = '0;
			end
		endcase
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			prescale <= '0;
			low1 <= 1'b0;
			low2 <= 1'b0;
			low3 <= 1'b0;
			low_div <= 3'h0;
			pin_prev <= 1'b0;
		end else if (CLK_EN) begin
			prescale <= prescale + 1'b1;
			low1 <= LOW_OSC_CLK;
			low2 <= low1;
			low3 <= low2;
			if (low_rise) begin
				low_div <= low_div + 3'h1;
			end
			pin_prev <= pin_level;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			START_CTRL_FIELD <= `START_STOP;
			PERIOD_COMPARE_REG <= `PERIOD_RESET;
		end else if (CLK_EN) begin
			if (STOP_ENTRY) begin
				START_CTRL_FIELD <= `START_STOP; // [R21]
			end else if (START_WR) begin
				START_CTRL_FIELD <= START_WDATA;
			end
			if (PERIOD_WR) begin
				PERIOD_COMPARE_REG <= PERIOD_WDATA;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			COUNT_VALUE <= `COUNT_RESET; // [R22]
			CAPTURE_REG <= `CAPTURE_RESET;
			RUNNING <= 1'b0;
			MATCH_IRQ <= 1'b0;
		end else if (CLK_EN) begin
			COUNT_VALUE <= next_count;
			RUNNING <= next_running;
			MATCH_IRQ <= next_irq;
			// value is stale until the first tick after enabling [R05] [R06]
			if (AUTO_CAPTURE_EN && advance) begin
				CAPTURE_REG <= COUNT_VALUE; // [R04] [R17]
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking dc @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	chk_timer_wrap: assert property (CLK_EN && kind == RUN_TIMER && src_tick && at_period // [R03]
		|=> COUNT_VALUE == '0 && MATCH_IRQ)
		else $error("timer did not wrap with irq on match");
	chk_timer_count: assert property (CLK_EN && kind == RUN_TIMER && src_tick && !at_period // [R02]
		|=> COUNT_VALUE == $past(COUNT_VALUE) + 1'b1)
		else $error("timer did not advance on tick");
	chk_ext_match: assert property (CLK_EN && kind == RUN_EXT && RUNNING && src_tick && at_period // [R08]
		&& !(TRIGGER_STOP_SEL && opp_edge) |=> !RUNNING && MATCH_IRQ && COUNT_VALUE == '0)
		else $error("trigger match did not halt with irq");
	chk_ext_abort: assert property (CLK_EN && kind == RUN_EXT && RUNNING && TRIGGER_STOP_SEL // [R09]
		&& opp_edge |=> !RUNNING && !MATCH_IRQ && COUNT_VALUE == '0)
		else $error("opposite edge did not abort silently");
	chk_ext_wait: assert property (CLK_EN && kind == RUN_EXT && !RUNNING && !trig_edge // [R07]
		|=> !RUNNING && COUNT_VALUE == $past(COUNT_VALUE))
		else $error("halted counter moved without trigger");
	chk_ext_retrig: assert property (CLK_EN && kind == RUN_EXT && RUNNING && !TRIGGER_STOP_SEL // [R11]
		&& !src_tick |=> RUNNING && COUNT_VALUE == $past(COUNT_VALUE))
		else $error("start-only counter disturbed by pin edge");
	chk_event_count: assert property (CLK_EN && kind == RUN_EVENT && trig_edge // [R14]
		|=> COUNT_VALUE == $past(COUNT_VALUE) + 1'b1 && !MATCH_IRQ)
		else $error("event edge not counted");
	chk_event_match: assert property (CLK_EN && kind == RUN_EVENT && opp_edge && at_period // [R15]
		|=> MATCH_IRQ && COUNT_VALUE == '0)
		else $error("event match missed on opposite edge");
	chk_capture_copy: assert property (CLK_EN && AUTO_CAPTURE_EN && advance // [R04]
		|=> CAPTURE_REG == $past(COUNT_VALUE))
		else $error("capture register not loaded");
	chk_stop_entry: assert property (CLK_EN && STOP_ENTRY // [R21]
		|=> START_CTRL_FIELD == `START_STOP ##1 COUNT_VALUE == '0 || !CLK_EN)
		else $error("stop entry did not stop the timer");
	chk_idle_modes: assert property (CLK_EN && !timer_family // [R01]
		|=> COUNT_VALUE == '0 && !MATCH_IRQ)
		else $error("unsupported mode moved the counter");

	cov_timer_wrap: cover property (kind == RUN_TIMER && MATCH_IRQ);
	cov_ext_abort: cover property (kind == RUN_EXT && RUNNING && TRIGGER_STOP_SEL && opp_edge);
	cov_event_match: cover property (kind == RUN_EVENT && MATCH_IRQ);
	cov_capture: cover property (AUTO_CAPTURE_EN && advance);
endmodule

//--- sim/pulse_source.sv
// Purpose: external pulse source on the timer input pin
// Assumes: levels change just after a falling clock edge
// Notes: driven by task calls from the bench
module pulse_source (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// level driver
	// ----------------------------------------
	initial pin = 1'b0;
	// no level shorter than two machine cycles, even for a noise glitch
	task automatic hold(input logic v, input int cyc);
		int n;
		n = (cyc < 2) ? 2 : cyc;
		@(negedge clk);
		pin = v;
		repeat (n - 1) @(negedge clk);
	endtask
endmodule

//--- sim/timer_trigger_event_counter_test.sv
// Purpose: self-checking bench of the timer/event counter
// Assumes: 20 MHz clock, pin edges seen about 12 cycles late
// Notes: low clock and doze state stay parked
module timer_trigger_event_counter_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and instances
	// ----------------------------------------
	logic mclk = 0, sys_rst = 1, clk_en = 1, start_wr = 0, period_wr = 0, stop_entry = 0;
	logic [1:0] start_wdata = 0, src = 0, mode = 0;
	logic stop_sel = 0, acap = 0, slow = 0;
	logic [15:0] period_wdata = 0;
	logic [1:0] start_field;
	logic [15:0] period_reg, capture, count;
	logic running, irq, pin;
	int errors = 0, n_tests = 0, irqs = 0, cycles = 0, n;
	initial forever #25 mclk = ~mclk;
	pulse_source i_pulse_source (.clk(mclk), .pin(pin));
	timer_trigger_event_counter i_timer_trigger_event_counter (.MCLK(mclk),
		.SYS_RST(sys_rst), .CLK_EN(clk_en), .TIMER_INPUT_PIN(pin), .LOW_OSC_CLK(1'b0),
		.START_WR(start_wr), .START_WDATA(start_wdata), .STOP_ENTRY(stop_entry),
		.PERIOD_WR(period_wr), .PERIOD_WDATA(period_wdata), .SOURCE_CLK_SEL(src),
		.OP_MODE_SEL(mode), .TRIGGER_STOP_SEL(stop_sel), .AUTO_CAPTURE_EN(acap),
		.DIVIDER_TAP_SEL(1'b0), .LOW_SPEED_STATE(slow), .DOZE_STATE(1'b0),
		.START_CTRL_FIELD(start_field), .PERIOD_COMPARE_REG(period_reg),
		.CAPTURE_REG(capture), .COUNT_VALUE(count), .RUNNING(running), .MATCH_IRQ(irq));
	// a hang is cut short well past the longest scenario
	always @(posedge mclk) begin
		irqs <= irqs + (irq === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic write_start(input logic [1:0] v);
		@(negedge mclk);
		start_wr = 1;
		start_wdata = v;
		@(negedge mclk);
		start_wr = 0;
	endtask
	task automatic write_period(input logic [15:0] v);
		@(negedge mclk);
		period_wr = 1;
		period_wdata = v;
		@(negedge mclk);
		period_wr = 0;
	endtask
	// cycles until the irq pulse, checked at the falling edge
	task automatic wait_irq(input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(negedge mclk);
			if (irq === 1'b1) return;
		end
		chk_bit(irq, 1'b1);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_timer();
		src = 2'h2;
		acap = 1;
		write_period(16'h0002);
		chk_val(period_reg, 16'h0002);
		write_start(2'h1);
		wait_irq(100, n);
		chk_val(count, 16'h0000);
		chk_val(capture, 16'h0002);
		wait_irq(100, n);
		chk_val(n, 24);
		@(negedge mclk);
		stop_entry = 1;
		start_wr = 1;
		@(negedge mclk);
		stop_entry = 0;
		start_wr = 0;
		repeat (2) @(negedge mclk);
		chk_val(start_field, 2'h0);
		chk_val(count, 16'h0000);
	endtask
	task automatic t_trig_only();
		write_period(16'h0014);
		write_start(2'h2);
		i_pulse_source.hold(1, 30);
		chk_bit(running, 1'b1);
		i_pulse_source.hold(0, 30);
		chk_bit(running, 1'b1);
		i_pulse_source.hold(1, 30);
		// a restart on the second rise would push the irq past this bound
		wait_irq(120, n);
		@(negedge mclk);
		chk_bit(running, 1'b0);
		chk_val(count, 16'h0000);
		i_pulse_source.hold(0, 30);
		i_pulse_source.hold(1, 4);
		i_pulse_source.hold(0, 30);
		chk_bit(running, 1'b0);
		i_pulse_source.hold(1, 12);
		i_pulse_source.hold(0, 20);
		chk_bit(running, 1'b1);
		write_start(2'h0);
	endtask
	task automatic t_trig_stop();
		stop_sel = 1;
		write_start(2'h2);
		i_pulse_source.hold(1, 30);
		chk_bit(running, 1'b1);
		n = irqs;
		i_pulse_source.hold(0, 30);
		chk_bit(running, 1'b0);
		chk_val(count, 16'h0000);
		chk_val(irqs, n);
		i_pulse_source.hold(1, 20);
		chk_bit(running, 1'b1);
		chk_bit(count < 16'h0004, 1'b1);
		write_start(2'h0);
		i_pulse_source.hold(0, 20);
	endtask
	task automatic t_event();
		src = 2'h3;
		stop_sel = 0;
		write_period(16'h0002);
		write_start(2'h2);
		n = irqs;
		repeat (2) begin
			i_pulse_source.hold(1, 16);
			i_pulse_source.hold(0, 16);
		end
		chk_val(irqs, n + 1);
		chk_val(count, 16'h0000);
		chk_val(capture, 16'h0001);
		i_pulse_source.hold(1, 16);
		chk_val(count, 16'h0001);
	endtask
	// a window selection must not count even with a command start
	task automatic t_modes();
		write_start(2'h0);
		src = 2'h2;
		mode = 2'h1;
		write_start(2'h1);
		repeat (20) @(negedge mclk);
		chk_val(count, 16'h0000);
		chk_bit(running, 1'b0);
		write_start(2'h0);
		mode = 2'h0;
	endtask
	// a 3-cycle pulse only gets through with the filter bypassed
	task automatic t_slow();
		slow = 1;
		stop_sel = 0;
		i_pulse_source.hold(0, 8);
		write_start(2'h2);
		i_pulse_source.hold(1, 3);
		i_pulse_source.hold(0, 10);
		chk_bit(running, 1'b1);
		chk_val(count, 16'h0000);
		write_start(2'h0);
		slow = 0;
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		chk_val(count, 16'h0000);
		chk_val(capture, 16'h0000);
		chk_val(start_field, 2'h0);
		chk_val(period_reg, 16'hffff);
		chk_bit(running, 1'b0);
		chk_bit(irq, 1'b0);
		sys_rst = 0;
		t_timer();
		t_trig_only();
		t_trig_stop();
		t_event();
		t_modes();
		t_slow();
		give_verdict();
	end
endmodule
